// ===== include/dram_host_cfg.svh
// Timing and geometry constants for the dynamic memory host controller.
// Assumes a 10 MHz core clock; every cycle count except INIT_CYCLES is derived from a time.
`ifndef DRAM_HOST_CFG_SVH
`define DRAM_HOST_CFG_SVH

`define CLK_PERIOD_NS     100
`define ADDR_BITS         18
`define LINE_BITS         9
`define ROW_LSB           9
`define COL_LSB           0
`define SYNC_STAGES       2
`define CAS_ACCESS_NS     40
`define CAS_ACCESS_CYC    ((`CAS_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_SAMPLE_CNT   (`CAS_ACCESS_CYC + `SYNC_STAGES)
`define POWERUP_US        200
`define POWERUP_CYC       ((`POWERUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_MS        4
`define REFRESH_ROWS      256
`define REFRESH_GAP_CYC   ((`REFRESH_MS * 1000000 / `REFRESH_ROWS) / `CLK_PERIOD_NS)
`define INIT_CYCLES       8
`define TIMER_BITS        16
`define CNT_BITS          4

`endif

// ===== include/dram_host_pkg.sv
// Types shared by the dynamic memory host controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
package dram_host_pkg;

	typedef enum logic [1:0] {
		CMD_READ,
		CMD_WRITE,
		CMD_RMW
	} cmd_t;

	typedef enum {
		ST_WAIT_POWER,
		ST_INIT_ADDR,
		ST_INIT_RAS,
		ST_IDLE,
		ST_ROW,
		ST_COL,
		ST_CAS,
		ST_WLOW,
		ST_CBR_CAS,
		ST_CBR_RAS,
		ST_PRE
	} state_t;

endpackage : dram_host_pkg

// ===== include/sched_if.sv
// Carrier between the refresh scheduler and the strobe sequencer.
// Both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none

interface sched_if;
	logic powerup_done;
	logic refresh_req;
	logic refresh_ack;

	modport timer (
		output powerup_done,
		output refresh_req,
		input  refresh_ack
	);

	modport ctrl (
		input  powerup_done,
		input  refresh_req,
		output refresh_ack
	);
endinterface : sched_if

`default_nettype wire

// ===== hdl/refresh_sched.sv
// Power-up pause timer and periodic refresh request generator.
// Assumes the sequencer acknowledges each request with a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "dram_host_cfg.svh"

module refresh_sched
	import dram_host_pkg::*;
#(
	parameter int POWERUP_CYC     = `POWERUP_CYC,
	parameter int REFRESH_GAP_CYC = `REFRESH_GAP_CYC
) (
	// Clock and reset.
	input  wire logic core_clk,
	input  wire logic srst,
	// Sequencer side.
	sched_if.timer    sch
);

	if (POWERUP_CYC < 1 || POWERUP_CYC >= (1 << `TIMER_BITS)) begin : g_chk_pu
		$error("POWERUP_CYC out of range");
	end
	if (REFRESH_GAP_CYC < 1 || REFRESH_GAP_CYC >= (1 << `TIMER_BITS)) begin : g_chk_rf
		$error("REFRESH_GAP_CYC out of range");
	end

	logic [`TIMER_BITS-1:0] timer_r;
	logic [`TIMER_BITS-1:0] timer_nxt;
	logic                   done_r;
	logic                   done_nxt;
	logic                   req_r;
	logic                   req_nxt;

	always_comb begin
		timer_nxt = timer_r;
		done_nxt  = done_r;
		req_nxt   = req_r;
		if (!done_r) begin
			// The pause runs out before any strobe may move.
			if (timer_r == `TIMER_BITS'(POWERUP_CYC - 1)) begin
				done_nxt  = 1'b1;
				timer_nxt = '0;
			end else begin
				timer_nxt = timer_r + `TIMER_BITS'(1);
			end
		end else begin
			// One row every gap keeps all rows inside the refresh period. The
			// request stays pending if the sequencer is busy, so none is lost.
			if (timer_r == `TIMER_BITS'(REFRESH_GAP_CYC - 1)) begin
				timer_nxt = '0;
				req_nxt   = 1'b1;
			end else begin
				timer_nxt = timer_r + `TIMER_BITS'(1);
			end
			if (sch.refresh_ack && !(timer_r == `TIMER_BITS'(REFRESH_GAP_CYC - 1))) begin
				req_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			timer_r <= '0;
			done_r  <= 1'b0;
			req_r   <= 1'b0;
		end else begin
			timer_r <= timer_nxt;
			done_r  <= done_nxt;
			req_r   <= req_nxt;
		end
	end

	assign sch.powerup_done = done_r;
	assign sch.refresh_req  = req_r;

endmodule : refresh_sched

`default_nettype wire

// ===== hdl/dram_host_ctrl.sv
// Host controller that drives a 256K x 1 dynamic memory through its strobe pins.
// Assumes the memory's data output arrives unsynchronised and the clock runs at 10 MHz.
//
// Operation
// - Address stable before each strobe falls
// - Refresh all 256 rows every 4 ms
// - Row-only cycle refreshes, output floating
// - Column before row requests internal refresh
// - Hidden refresh keeps read data valid; the controller refreshes only in separate column-before-row cycles
// - Page mode repeats columns in row; the controller opens and closes the row for every access
// - Wait 200 us, then eight init cycles
`timescale 1ns/1ps
`default_nettype none
`include "dram_host_cfg.svh"

module dram_host_ctrl
	import dram_host_pkg::*;
#(
	parameter int POWERUP_CYC     = `POWERUP_CYC,
	parameter int REFRESH_GAP_CYC = `REFRESH_GAP_CYC
) (
	// Clock and reset.
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	// User request port.
	input  wire logic                  req_valid,
	output logic                       req_ready,
	input  wire cmd_t                  req_cmd,
	input  wire logic [`ADDR_BITS-1:0] req_addr,
	input  wire logic                  req_wdata,
	// User response port.
	output logic                       rsp_valid,
	output logic                       rsp_rdata,
	output logic                       init_done,
	// Memory pins.
	output logic                       row_strobe_n,
	output logic                       col_strobe_n,
	output logic                       write_en_n,
	output logic [`LINE_BITS-1:0]      mux_address_lines,
	output logic                       data_to_mem,
	input  wire logic                  data_from_mem
);

	sched_if sch ();

	refresh_sched #(
		.POWERUP_CYC     (POWERUP_CYC),
		.REFRESH_GAP_CYC (REFRESH_GAP_CYC)
	) u_sched (
		.core_clk (core_clk),
		.srst     (srst),
		.sch      (sch)
	);

	// Two-stage synchroniser on the memory's unlatched output.
	logic q_meta_r;
	logic q_sync_r;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			q_meta_r <= 1'b0;
			q_sync_r <= 1'b0;
		end else begin
			q_meta_r <= data_from_mem;
			q_sync_r <= q_meta_r;
		end
	end

	state_t                 state_r;
	state_t                 state_nxt;
	logic [`CNT_BITS-1:0]   cnt_r;
	logic [`CNT_BITS-1:0]   cnt_nxt;
	cmd_t                   cmd_r;
	cmd_t                   cmd_nxt;
	logic [`ADDR_BITS-1:0]  addr_r;
	logic [`ADDR_BITS-1:0]  addr_nxt;
	logic                   wdata_r;
	logic                   wdata_nxt;
	logic                   ras_n_r;
	logic                   ras_n_nxt;
	logic                   cas_n_r;
	logic                   cas_n_nxt;
	logic                   we_n_r;
	logic                   we_n_nxt;
	logic [`LINE_BITS-1:0]  lines_r;
	logic [`LINE_BITS-1:0]  lines_nxt;
	logic                   dout_r;
	logic                   dout_nxt;
	logic                   rsp_valid_r;
	logic                   rsp_valid_nxt;
	logic                   rsp_rdata_r;
	logic                   rsp_rdata_nxt;
	logic                   init_done_r;
	logic                   init_done_nxt;
	logic                   ack;

	always_comb begin
		state_nxt     = state_r;
		cnt_nxt       = cnt_r;
		cmd_nxt       = cmd_r;
		addr_nxt      = addr_r;
		wdata_nxt     = wdata_r;
		ras_n_nxt     = ras_n_r;
		cas_n_nxt     = cas_n_r;
		we_n_nxt      = we_n_r;
		lines_nxt     = lines_r;
		dout_nxt      = dout_r;
		rsp_valid_nxt = 1'b0;
		rsp_rdata_nxt = rsp_rdata_r;
		init_done_nxt = init_done_r;
		ack           = 1'b0;
		case (state_r)
			ST_WAIT_POWER: begin
				if (sch.powerup_done) begin
					cnt_nxt   = '0;
					state_nxt = ST_INIT_ADDR;
				end
			end
			ST_INIT_ADDR: begin
				// Init cycles are row-only cycles over successive rows.
				lines_nxt = `LINE_BITS'(cnt_r);
				state_nxt = ST_INIT_RAS;
			end
			ST_INIT_RAS: begin
				ras_n_nxt = 1'b0;
				cnt_nxt   = cnt_r + `CNT_BITS'(1);
				if (cnt_r == `CNT_BITS'(`INIT_CYCLES - 1)) begin
					init_done_nxt = 1'b1;
				end
				state_nxt = ST_PRE;
			end
			ST_IDLE: begin
				if (sch.refresh_req) begin
					// Refresh takes priority so the row budget is never overrun.
					ack       = 1'b1;
					state_nxt = ST_CBR_CAS;
				end else if (req_valid) begin
					cmd_nxt   = req_cmd;
					addr_nxt  = req_addr;
					wdata_nxt = req_wdata;
					lines_nxt = req_addr[`ROW_LSB +: `LINE_BITS];
					state_nxt = ST_ROW;
				end
			end
			ST_ROW: begin
				ras_n_nxt = 1'b0;
				state_nxt = ST_COL;
			end
			ST_COL: begin
				lines_nxt = addr_r[`COL_LSB +: `LINE_BITS];
				if (cmd_r == CMD_WRITE) begin
					// Early write: the data pin is free of memory output all cycle.
					we_n_nxt = 1'b0;
					dout_nxt = wdata_r;
				end else begin
					we_n_nxt = 1'b1;
				end
				cnt_nxt   = '0;
				state_nxt = ST_CAS;
			end
			ST_CAS: begin
				cas_n_nxt = 1'b0;
				cnt_nxt   = cnt_r + `CNT_BITS'(1);
				if (cmd_r == CMD_WRITE) begin
					state_nxt     = ST_PRE;
					rsp_valid_nxt = 1'b1;
				end else if (cnt_r == `CNT_BITS'(`READ_SAMPLE_CNT)) begin
					// Sampled only after the access time plus the synchroniser.
					rsp_rdata_nxt = q_sync_r;
					if (cmd_r == CMD_RMW) begin
						dout_nxt  = wdata_r;
						state_nxt = ST_WLOW;
					end else begin
						rsp_valid_nxt = 1'b1;
						state_nxt     = ST_PRE;
					end
				end
			end
			ST_WLOW: begin
				// Delayed write: the column strobe is still low, write-enable strobes data.
				we_n_nxt      = 1'b0;
				rsp_valid_nxt = 1'b1;
				state_nxt     = ST_PRE;
			end
			ST_CBR_CAS: begin
				cas_n_nxt = 1'b0;
				state_nxt = ST_CBR_RAS;
			end
			ST_CBR_RAS: begin
				ras_n_nxt = 1'b0;
				state_nxt = ST_PRE;
			end
			ST_PRE: begin
				// Both strobes high for one full cycle covers the precharge time.
				// Every access closes its row here, so neither strobe nears its longest low time.
				ras_n_nxt = 1'b1;
				cas_n_nxt = 1'b1;
				we_n_nxt  = 1'b1;
				state_nxt = (ras_n_r && cas_n_r) ? (init_done_r ? ST_IDLE : ST_INIT_ADDR) : ST_PRE;
			end
			default: begin
				state_nxt = ST_WAIT_POWER;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r     <= ST_WAIT_POWER;
			cnt_r       <= '0;
			cmd_r       <= CMD_READ;
			addr_r      <= '0;
			wdata_r     <= 1'b0;
			ras_n_r     <= 1'b1;
			cas_n_r     <= 1'b1;
			we_n_r      <= 1'b1;
			lines_r     <= '0;
			dout_r      <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_rdata_r <= 1'b0;
			init_done_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			cmd_r       <= cmd_nxt;
			addr_r      <= addr_nxt;
			wdata_r     <= wdata_nxt;
			ras_n_r     <= ras_n_nxt;
			cas_n_r     <= cas_n_nxt;
			we_n_r      <= we_n_nxt;
			lines_r     <= lines_nxt;
			dout_r      <= dout_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			rsp_rdata_r <= rsp_rdata_nxt;
			init_done_r <= init_done_nxt;
		end
	end

	assign sch.refresh_ack    = ack;
	assign req_ready          = (state_r == ST_IDLE) && !sch.refresh_req;
	assign rsp_valid          = rsp_valid_r;
	assign rsp_rdata          = rsp_rdata_r;
	assign init_done          = init_done_r;
	assign row_strobe_n       = ras_n_r;
	assign col_strobe_n       = cas_n_r;
	assign write_en_n         = we_n_r;
	assign mux_address_lines  = lines_r;
	assign data_to_mem        = dout_r;

endmodule : dram_host_ctrl

`default_nettype wire

// ===== testbench/dram_host_monitor.sv
// Concurrent checks on the dynamic memory host controller's ports.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "dram_host_cfg.svh"
module dram_host_monitor #(
	parameter int POWERUP_CYC     = 2000,
	parameter int REFRESH_GAP_CYC = 156
) (
	// Clock and reset.
	input wire logic                 core_clk,
	input wire logic                 srst,
	// Observed ports.
	input wire logic                 req_ready,
	input wire logic                 rsp_valid,
	input wire logic                 init_done,
	input wire logic                 row_strobe_n,
	input wire logic                 col_strobe_n,
	input wire logic                 write_en_n,
	input wire logic [`LINE_BITS-1:0] mux_address_lines
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic [15:0] up_r;
	logic [15:0] gap_r;
	logic [3:0]  ras_r;
	// The gap counter restarts on each column-first refresh, so it measures the refresh spacing.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			up_r  <= 16'h0000;
			gap_r <= 16'h0000;
			ras_r <= 4'h0;
		end else begin
			up_r  <= (up_r == 16'hffff) ? up_r : up_r + 16'h0001;
			gap_r <= (!init_done || (!col_strobe_n && row_strobe_n)) ? 16'h0000 : gap_r + 16'h0001;
			if ((!init_done || $rose(init_done)) && $fell(row_strobe_n)) ras_r <= ras_r + 4'h1;
		end
	end
	sequence cbr_start;
		$fell(col_strobe_n) && row_strobe_n;
	endsequence
	sequence cbr_rest;
		$fell(row_strobe_n) && !col_strobe_n ##1 row_strobe_n && col_strobe_n;
	endsequence
	sequence cas_hold;
		!col_strobe_n [*2];
	endsequence
	a_cbr_order: assert property (cbr_start |=> cbr_rest) else $error("refresh strobe order wrong");
	a_row_addr_stable: assert property ($fell(row_strobe_n) && col_strobe_n |-> $stable(mux_address_lines))
		else $error("row address moved at row strobe");
	a_col_addr_stable: assert property ($fell(col_strobe_n) && !row_strobe_n |-> $stable(mux_address_lines))
		else $error("column address moved at column strobe");
	a_read_hold: assert property ($fell(col_strobe_n) && !row_strobe_n && write_en_n
		|=> cas_hold ##1 (rsp_valid or (!col_strobe_n ##1 (!write_en_n && rsp_valid))))
		else $error("read column window wrong");
	a_ready_idle: assert property (req_ready |-> init_done && row_strobe_n && col_strobe_n)
		else $error("ready outside idle");
	a_powerup_pause: assert property ($fell(row_strobe_n) |-> up_r >= POWERUP_CYC)
		else $error("row strobe before pause");
	a_init_count: assert property ($rose(init_done) |=> ras_r == 4'h8) else $error("init cycle count wrong");
	a_refresh_gap: assert property (gap_r < REFRESH_GAP_CYC + 32) else $error("refresh too late");
endmodule : dram_host_monitor
bind dram_host_ctrl dram_host_monitor #(
	.POWERUP_CYC(POWERUP_CYC),
	.REFRESH_GAP_CYC(REFRESH_GAP_CYC)
) dram_host_monitor_inst (
	.core_clk(core_clk),
	.srst(srst),
	.req_ready(req_ready),
	.rsp_valid(rsp_valid),
	.init_done(init_done),
	.row_strobe_n(row_strobe_n),
	.col_strobe_n(col_strobe_n),
	.write_en_n(write_en_n),
	.mux_address_lines(mux_address_lines)
);
`default_nettype wire

// ===== testbench/dram_model.sv
// Behavioural 256K x 1 dynamic memory, page variant, or nibble variant when NIBBLE is set.
// Assumes the strobes come from registered controller outputs.
`timescale 1ns/1ps
`default_nettype none
module dram_model #(
	parameter bit NIBBLE = 1'b0
) (
	// Memory pins.
	input  wire logic       row_strobe_n,
	input  wire logic       col_strobe_n,
	input  wire logic       write_en_n,
	input  wire logic [8:0] mux_address_lines,
	input  wire logic       data_to_mem,
	output logic            data_from_mem
);
	logic        mem [0:262143];
	logic [8:0]  row_r;
	logic [17:0] addr;
	int          ref_cnt;
	logic [1:0]  nib_pos;
	logic        in_burst;
	initial begin
		data_from_mem = 1'b0;
		ref_cnt = 0;
		nib_pos = 2'h0;
		in_burst = 1'b0;
	end
	always @(posedge row_strobe_n) in_burst = 1'b0;
	always @(negedge row_strobe_n) begin
		if (!col_strobe_n) ref_cnt++;
		else row_r = mux_address_lines;
	end
	always @(negedge col_strobe_n) begin
		if (!row_strobe_n) begin
			if (NIBBLE && in_burst) begin
				// Later bits of a burst walk the four-bit group and ignore the pins.
				nib_pos = nib_pos + 2'h1;
				addr = {nib_pos[0], addr[16:9], nib_pos[1], addr[7:0]};
			end else begin
				addr = {row_r, mux_address_lines};
				nib_pos = {addr[8], addr[17]};
			end
			in_burst = 1'b1;
			if (!write_en_n) begin
				mem[addr] = data_to_mem;
			end else begin
				data_from_mem = ~mem[addr];
				#40;
				if (!col_strobe_n) data_from_mem = mem[addr];
			end
		end
	end
	always @(negedge write_en_n) begin
		if (!row_strobe_n && !col_strobe_n) mem[addr] = data_to_mem;
	end
	// Nothing pulls the released pin, so it shows the inverse of its last value.
	always @(posedge col_strobe_n) data_from_mem = ~data_from_mem;
endmodule : dram_model
`default_nettype wire

// ===== testbench/test_dram_host_ctrl.sv
// Self-checking bench for the dynamic memory host controller.
// Assumes the memory model file and the bound monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module test_dram_host_ctrl
	import dram_host_pkg::*;
;
	localparam int PU_CYC = 20;
	localparam int GAP_CYC = 30;
	logic        core_clk, srst, req_valid, req_ready, req_wdata, rsp_valid, rsp_rdata, init_done;
	logic        row_strobe_n, col_strobe_n, write_en_n, data_to_mem, data_from_mem, q;
	cmd_t        req_cmd;
	logic [17:0] req_addr;
	logic [8:0]  mux_address_lines;
	int          fails, checks_done;
	logic [17:0] addrs [4] = '{18'h00000, 18'h3ffff, 18'h00001, 18'h00200};
	dram_host_ctrl #(.POWERUP_CYC(PU_CYC), .REFRESH_GAP_CYC(GAP_CYC)) dram_host_ctrl_inst (
		.core_clk(core_clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
		.req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .init_done(init_done), .row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n), .write_en_n(write_en_n), .mux_address_lines(mux_address_lines),
		.data_to_mem(data_to_mem), .data_from_mem(data_from_mem));
	dram_model dram_model_inst (
		.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
		.mux_address_lines(mux_address_lines), .data_to_mem(data_to_mem), .data_from_mem(data_from_mem));
	always #50 core_clk = ~core_clk;
	task end_of_test;
		if (fails == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_of_test
	// The request is held until a falling edge sees ready, so the next rising edge takes it.
	task automatic access(input cmd_t c, input logic [17:0] a, input logic d, output logic r);
		int n;
		n = 0;
		@(negedge core_clk);
		req_valid = 1'b1;
		req_cmd = c;
		req_addr = a;
		req_wdata = d;
		while (req_ready !== 1'b1 && n < 100) begin @(negedge core_clk); n++; end
		@(negedge core_clk);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 100) begin @(negedge core_clk); n++; end
		if (n >= 100) fails++;
		r = rsp_rdata;
	endtask : access
	task t_init;
		int n;
		n = 0;
		while (init_done !== 1'b1 && n < 400) begin @(negedge core_clk); n++; end
		`CHK(init_done, 1'b1)
		`CHK(n > PU_CYC + 16, 1'b1)
	endtask : t_init
	task t_wr_rd;
		for (int i = 0; i < 4; i++) begin
			access(CMD_WRITE, addrs[i], ~i[0], q);
			`CHK(dram_model_inst.mem[addrs[i]], ~i[0])
		end
		for (int i = 0; i < 4; i++) begin
			access(CMD_READ, addrs[i], 1'b0, q);
			`CHK(q, ~i[0])
		end
	endtask : t_wr_rd
	task t_rmw;
		access(CMD_RMW, 18'h3ffff, 1'b1, q);
		`CHK(q, 1'b0)
		`CHK(dram_model_inst.mem[18'h3ffff], 1'b1)
		access(CMD_READ, 18'h3ffff, 1'b0, q);
		`CHK(q, 1'b1)
	endtask : t_rmw
	task t_refresh;
		int n0;
		n0 = dram_model_inst.ref_cnt;
		repeat (200) @(negedge core_clk);
		`CHK(dram_model_inst.ref_cnt - n0 > 3, 1'b1)
		access(CMD_READ, 18'h00000, 1'b0, q);
		`CHK(q, 1'b1)
	endtask : t_refresh
	initial begin
		#500000;
		fails++;
		end_of_test();
	end
	initial begin
		core_clk = 1'b0;
		srst = 1'b1;
		req_valid = 1'b0;
		req_cmd = CMD_READ;
		req_addr = 18'h00000;
		req_wdata = 1'b0;
		fails = 0;
		checks_done = 0;
		repeat (10) @(negedge core_clk);
		srst = 1'b0;
		t_init();
		t_wr_rd();
		t_rmw();
		t_refresh();
		end_of_test();
	end
endmodule : test_dram_host_ctrl
`default_nettype wire
